// ### rtl/sos_pkg.sv
// shared constants and types for the status output signal select block
package sos_pkg;

  // select codes
  localparam logic [5:0] SEL_PKT_SYNC   = 6'h06;
  localparam logic [5:0] SEL_CRC_PKT    = 6'h07;
  localparam logic [5:0] SEL_PQ_REACHED = 6'h08;
  localparam logic [5:0] SEL_CLEAR_CHAN = 6'h09;
  localparam logic [5:0] SEL_PLL_LOCK   = 6'h0A;
  localparam logic [5:0] SEL_SER_CLK    = 6'h0B;
  localparam logic [5:0] SEL_SYNC_DATA  = 6'h0C;
  localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
  localparam logic [5:0] SEL_CARRIER    = 6'h0E;
  localparam logic [5:0] SEL_CRC_MATCH  = 6'h0F;
  localparam logic [5:0] SEL_HARD_BIT1  = 6'h16;
  localparam logic [5:0] SEL_HARD_BIT0  = 6'h17;
  localparam logic [5:0] SEL_SYM_TICK   = 6'h1D;
  localparam logic [5:0] SEL_WOR_EVT0   = 6'h24;
  localparam logic [5:0] SEL_WOR_EVT1   = 6'h25;
  localparam logic [5:0] SEL_SLOW_CLK   = 6'h27;
  localparam logic [5:0] SEL_SLEEP_LIVE = 6'h20;

  // register byte addresses
  localparam logic [4:0] ADR_CFG0   = 5'h00;
  localparam logic [4:0] ADR_CFG1   = 5'h04;
  localparam logic [4:0] ADR_CFG2   = 5'h08;
  localparam logic [4:0] ADR_THR    = 5'h0C;
  localparam logic [4:0] ADR_CCA    = 5'h10;
  localparam logic [4:0] ADR_STATUS = 5'h14;

  // field positions
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_INV_BIT  = 6;
  localparam int THR_PQT_LSB  = 0;
  localparam int THR_RSSI_LSB = 8;
  localparam int ST_PINS_LSB  = 0;
  localparam int ST_PKT_SYNC  = 3;
  localparam int ST_CRC_PKT   = 4;
  localparam int ST_CRC_MATCH = 5;
  localparam int ST_PLL_LOCK  = 6;
  localparam int ST_TX_BIT    = 7;
  localparam int ST_PQ        = 8;
  localparam int ST_CLEAR     = 9;
  localparam int ST_CARRIER   = 10;

  localparam int NUM_PINS = 3;

  typedef struct packed {
    logic       inv;
    logic [5:0] sel;
  } sos_pin_cfg_t;

  typedef enum logic [1:0] {
    CCA_ALWAYS,
    CCA_RSSI,
    CCA_NO_PKT,
    CCA_RSSI_NO_PKT
  } sos_channel_assessment_mode_t;

  // reset values
  localparam sos_pin_cfg_t CFG_RST      = 7'h00;
  localparam logic [7:0]   PQT_RST      = 8'h00;
  localparam logic [7:0]   RSSI_THR_RST = 8'h00;
  localparam logic [31:0]  UNMAPPED_RD  = 32'h0000_0000;

  // every internal signal a pin can show
  typedef struct packed {
    logic pkt_sync;
    logic crc_pkt;
    logic pq_reached;
    logic clear_chan;
    logic pll_lock;
    logic ser_clk;
    logic sync_data;
    logic async_data;
    logic carrier;
    logic crc_match;
    logic hard1;
    logic hard0;
    logic sym_tick;
    logic wor0;
    logic wor1;
    logic slow_clk;
  } sos_sig_t;

endpackage

// ### rtl/sos_pin_select.sv
// one output pin: select, sleep forcing, inversion, output register
`timescale 1ns/1ns
module sos_pin_select
  import sos_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         arst_n_i,
  input  sos_pkg::sos_pin_cfg_t cfg_i,
  input  sos_pkg::sos_sig_t sig_i,
  input  wire logic         sleep_i,
  input  wire logic         idle_level_i,
  output logic              pin_o
);

  logic chosen;
  logic forced;
  logic next_pin;

  always_comb
  begin
    chosen = 1'b0;
    unique case (cfg_i.sel)
      SEL_PKT_SYNC:   chosen = sig_i.pkt_sync;
      SEL_CRC_PKT:    chosen = sig_i.crc_pkt;
      SEL_PQ_REACHED: chosen = sig_i.pq_reached;
      SEL_CLEAR_CHAN: chosen = sig_i.clear_chan;
      SEL_PLL_LOCK:   chosen = sig_i.pll_lock;
      SEL_SER_CLK:    chosen = sig_i.ser_clk;
      SEL_SYNC_DATA:  chosen = sig_i.sync_data;
      SEL_ASYNC_DATA: chosen = sig_i.async_data;
      SEL_CARRIER:    chosen = sig_i.carrier;
      SEL_CRC_MATCH:  chosen = sig_i.crc_match;
      SEL_HARD_BIT1:  chosen = sig_i.hard1;
      SEL_HARD_BIT0:  chosen = sig_i.hard0;
      SEL_SYM_TICK:   chosen = sig_i.sym_tick;
      SEL_WOR_EVT0:   chosen = sig_i.wor0;
      SEL_WOR_EVT1:   chosen = sig_i.wor1;
      SEL_SLOW_CLK:   chosen = sig_i.slow_clk;
      // reserved and uncovered codes drive low
      default:        chosen = 1'b0;
    endcase
  end

  // low codes hold a fixed level in sleep, high codes keep running
  assign forced   = sleep_i && (cfg_i.sel < SEL_SLEEP_LIVE);
  assign next_pin = forced ? (idle_level_i ^ cfg_i.inv)
                           : (chosen ^ cfg_i.inv);

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_o <= 1'b0;
    else
      pin_o <= next_pin;
  end

endmodule // sos_pin_select

// ### rtl/sos_output_select.sv
// three general output pins with per-pin signal select and register bus
//
// Contract
// - code 0x06 rises when sync word sent or received, falls at packet end
// - code 0x06 falls early on address reject, rx overflow, tx underflow
// - code 0x07 rises on packet with good checksum, falls on first byte read
// - code 0x08 high while preamble quality exceeds programmed threshold
// - code 0x09 shows clear channel, criterion set by assessment mode
// - code 0x0A carries synthesizer lock detector level
// - code 0x0B carries serial clock; rx data changes on its falling edge
// - sync transmit data sampled on serial clock rising edge
// - code 0x0C carries synchronous receive data aligned to serial clock
// - code 0x0D carries asynchronous receive data, no clock
// - code 0x0E shows carrier sense, rssi above threshold
// - code 0x0F shows last checksum match, cleared on receive entry
// - codes 0x16 and 0x17 output hard-decision symbol bits one and zero
// - code 0x1D outputs the receive symbol tick
// - codes 0x24 and 0x25 output wake events zero and one
// - each pin has its own six-bit select field
// - codes 0x20 and up run in sleep; lower codes forced fixed
// - pin one valid only while interface select is high
`timescale 1ns/1ns
module sos_output_select
  import sos_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        sync_found_i,
  input  wire logic        packet_end_i,
  input  wire logic        addr_reject_i,
  input  wire logic        rx_overflow_i,
  input  wire logic        tx_underflow_i,
  input  wire logic        crc_ok_packet_i,
  input  wire logic        rx_first_read_i,
  input  wire logic        crc_done_i,
  input  wire logic        crc_equal_i,
  input  wire logic        rx_enter_i,
  input  wire logic [7:0]  preamble_quality_indicator_i,
  input  wire logic [7:0]  rssi_i,
  input  wire logic        receiving_packet_i,
  input  wire logic        pll_lock_i,
  input  wire logic        serial_clk_i,
  input  wire logic        rx_sync_bit_i,
  input  wire logic        rx_async_bit_i,
  input  wire logic [1:0]  receive_hard_decision_bits_i,
  input  wire logic        rx_symbol_tick_i,
  input  wire logic        wake_radio_event_zero_i,
  input  wire logic        wake_radio_event_one_i,
  input  wire logic        slow_timer_clock_i,
  input  wire logic        sleep_i,
  input  wire logic        tx_active_i,
  input  wire logic        interface_select_low_i,
  input  wire logic        general_output_pin_zero_i,
  output logic             general_output_pin_zero_o,
  output logic             general_output_pin_zero_oe_o,
  output logic             general_output_pin_one_o,
  output logic             general_output_pin_one_oe_o,
  output logic             general_output_pin_two_o,
  output logic             tx_bit_o,
  output logic             tx_bit_valid_o
);

  sos_pin_cfg_t  output_signal_select [NUM_PINS];
  logic [7:0]    preamble_quality_threshold;
  logic [7:0]    rssi_threshold;
  sos_channel_assessment_mode_t channel_assessment_mode;

  logic pkt_sync_flag;
  logic crc_pkt_flag;
  logic crc_match_flag;
  logic sync_data;
  logic ack;

  // two-stage synchronisers plus one history stage for edges
  logic [1:0] sclk_sync;
  logic       sclk_prev;
  logic [1:0] slow_sync;
  logic [1:0] sel_sync;
  logic [1:0] txd_sync;

  sos_sig_t sig;
  logic [NUM_PINS-1:0] pin_level;

  // serial clock edges, direction set by the clock pin's inversion
  wire sclk_rise = sclk_sync[1] && !sclk_prev;
  wire sclk_fall = !sclk_sync[1] && sclk_prev;
  wire clk_pin0  = output_signal_select[0].sel == SEL_SER_CLK;
  wire clk_pin1  = output_signal_select[1].sel == SEL_SER_CLK;
  wire ser_inv   = clk_pin0 ? output_signal_select[0].inv
                 : clk_pin1 ? output_signal_select[1].inv
                 : output_signal_select[2].inv;
  wire setup_edge  = ser_inv ? sclk_rise : sclk_fall;
  wire sample_edge = ser_inv ? sclk_fall : sclk_rise;

  // packet sync flag: set wins over every early clear
  wire sync_clear     = packet_end_i || addr_reject_i
                      || rx_overflow_i || tx_underflow_i;
  wire next_pkt_sync  = sync_found_i || (pkt_sync_flag && !sync_clear);
  wire next_crc_pkt   = crc_ok_packet_i
                      || (crc_pkt_flag && !rx_first_read_i);
  wire crc_load       = crc_done_i;
  wire next_crc_match = crc_load ? crc_equal_i
                      : (crc_match_flag && !rx_enter_i);

  wire pq_reached  = preamble_quality_indicator_i
                   > preamble_quality_threshold;
  wire rssi_below  = rssi_i < rssi_threshold;
  wire rssi_above  = rssi_i > rssi_threshold;
  logic clear_chan;

  always_comb
  begin
    clear_chan = 1'b1;
    unique case (channel_assessment_mode)
      CCA_ALWAYS:      clear_chan = 1'b1;
      CCA_RSSI:        clear_chan = rssi_below;
      CCA_NO_PKT:      clear_chan = !receiving_packet_i;
      CCA_RSSI_NO_PKT: clear_chan = rssi_below && !receiving_packet_i;
    endcase
  end

  assign sig.pkt_sync   = pkt_sync_flag;
  assign sig.crc_pkt    = crc_pkt_flag;
  assign sig.pq_reached = pq_reached;
  assign sig.clear_chan = clear_chan;
  assign sig.pll_lock   = pll_lock_i;
  assign sig.ser_clk    = sclk_sync[1];
  assign sig.sync_data  = sync_data;
  assign sig.async_data = rx_async_bit_i;
  assign sig.carrier    = rssi_above;
  assign sig.crc_match  = crc_match_flag;
  assign sig.hard1      = receive_hard_decision_bits_i[1];
  assign sig.hard0      = receive_hard_decision_bits_i[0];
  assign sig.sym_tick   = rx_symbol_tick_i;
  assign sig.wor0       = wake_radio_event_zero_i;
  assign sig.wor1       = wake_radio_event_one_i;
  assign sig.slow_clk   = slow_sync[1];

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pkt_sync_flag  <= 1'b0;
      crc_pkt_flag   <= 1'b0;
      crc_match_flag <= 1'b0;
    end
    else
    begin
      pkt_sync_flag  <= next_pkt_sync;
      crc_pkt_flag   <= next_crc_pkt;
      crc_match_flag <= next_crc_match;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_sync <= 2'b00;
      sclk_prev <= 1'b0;
      slow_sync <= 2'b00;
      sel_sync  <= 2'b00;
      txd_sync  <= 2'b00;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], serial_clk_i};
      sclk_prev <= sclk_sync[1];
      slow_sync <= {slow_sync[0], slow_timer_clock_i};
      sel_sync  <= {sel_sync[0], interface_select_low_i};
      txd_sync  <= {txd_sync[0], general_output_pin_zero_i};
    end
  end

  // receive data moves on the setup edge so the host samples mid-bit
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sync_data <= 1'b0;
    else if (setup_edge)
      sync_data <= rx_sync_bit_i;
  end

  // transmit bit taken from pin zero while transmit owns that pin
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_bit_o       <= 1'b0;
      tx_bit_valid_o <= 1'b0;
    end
    else
    begin
      tx_bit_valid_o <= sample_edge && tx_active_i;
      if (sample_edge && tx_active_i)
        tx_bit_o <= txd_sync[1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_pin
      // pin one idles high in sleep, the others low
      sos_pin_select u_pin (
        .mclk_i       (mclk_i),
        .arst_n_i     (arst_n_i),
        .cfg_i        (output_signal_select[g]),
        .sig_i        (sig),
        .sleep_i      (sleep_i),
        .idle_level_i (g == 1),
        .pin_o        (pin_level[g])
      );
    end
  endgenerate

  assign general_output_pin_zero_o    = pin_level[0];
  assign general_output_pin_zero_oe_o = !tx_active_i;
  assign general_output_pin_one_o     = pin_level[1];
  // pin one shares the serial data output of the control interface
  assign general_output_pin_one_oe_o  = sel_sync[1];
  assign general_output_pin_two_o     = pin_level[2];

  // bus slave: one wait cycle, then the answer
  wire req      = avs_read_i || avs_write_i;
  wire wr_take  = avs_write_i && ack;
  wire be0      = avs_byteenable_i[0];
  wire be1      = avs_byteenable_i[1];
  wire hit_cfg0 = avs_address_i == ADR_CFG0;
  wire hit_cfg1 = avs_address_i == ADR_CFG1;
  wire hit_cfg2 = avs_address_i == ADR_CFG2;
  wire hit_thr  = avs_address_i == ADR_THR;
  wire hit_cca  = avs_address_i == ADR_CCA;
  wire hit_st   = avs_address_i == ADR_STATUS;
  wire [6:0] wr_cfg = avs_writedata_i[CFG_INV_BIT:CFG_SEL_LSB];

  assign avs_waitrequest_o = req && !ack;

  logic [31:0] status_word;
  logic [31:0] next_rdata;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_PINS_LSB +: NUM_PINS] = pin_level;
    status_word[ST_PKT_SYNC]  = pkt_sync_flag;
    status_word[ST_CRC_PKT]   = crc_pkt_flag;
    status_word[ST_CRC_MATCH] = crc_match_flag;
    status_word[ST_PLL_LOCK]  = pll_lock_i;
    status_word[ST_TX_BIT]    = tx_bit_o;
    status_word[ST_PQ]        = pq_reached;
    status_word[ST_CLEAR]     = clear_chan;
    status_word[ST_CARRIER]   = rssi_above;
  end

  always_comb
  begin
    next_rdata = UNMAPPED_RD;
    if (hit_cfg0)
      next_rdata = {25'h0, output_signal_select[0]};
    else if (hit_cfg1)
      next_rdata = {25'h0, output_signal_select[1]};
    else if (hit_cfg2)
      next_rdata = {25'h0, output_signal_select[2]};
    else if (hit_thr)
      next_rdata = {16'h0000, rssi_threshold, preamble_quality_threshold};
    else if (hit_cca)
      next_rdata = {30'h0, channel_assessment_mode};
    else if (hit_st)
      next_rdata = status_word;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= UNMAPPED_RD;
    end
    else
    begin
      ack <= req && !ack;
      if (avs_read_i && !ack)
        avs_readdata_o <= next_rdata;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      output_signal_select[0]    <= CFG_RST;
      output_signal_select[1]    <= CFG_RST;
      output_signal_select[2]    <= CFG_RST;
      preamble_quality_threshold <= PQT_RST;
      rssi_threshold             <= RSSI_THR_RST;
      channel_assessment_mode    <= CCA_ALWAYS;
    end
    else if (wr_take)
    begin
      if (hit_cfg0 && be0)
        output_signal_select[0] <= wr_cfg;
      if (hit_cfg1 && be0)
        output_signal_select[1] <= wr_cfg;
      if (hit_cfg2 && be0)
        output_signal_select[2] <= wr_cfg;
      if (hit_thr && be0)
        preamble_quality_threshold <= avs_writedata_i[THR_PQT_LSB +: 8];
      if (hit_thr && be1)
        rssi_threshold <= avs_writedata_i[THR_RSSI_LSB +: 8];
      if (hit_cca && be0)
        channel_assessment_mode <= sos_channel_assessment_mode_t'(avs_writedata_i[1:0]);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_sclk_fall;
    !ser_inv && sclk_fall;
  endsequence

  sequence s_sclk_rise_tx;
    !ser_inv && sclk_rise && tx_active_i;
  endsequence

  a_sync_set_wins: assert property (
    sync_found_i |=> pkt_sync_flag)
    else $error("packet sync flag missed its set");

  a_sync_early_end: assert property (
    (sync_clear && !sync_found_i) |=> !pkt_sync_flag)
    else $error("packet sync flag did not drop");

  a_crc_pkt_read: assert property (
    (crc_pkt_flag && rx_first_read_i && !crc_ok_packet_i)
      |=> !crc_pkt_flag)
    else $error("checksum packet flag survived first read");

  a_crc_match_rx: assert property (
    (rx_enter_i && !crc_done_i) |=> !crc_match_flag)
    else $error("checksum match not cleared on receive entry");

  a_rx_setup_edge: assert property (
    s_sclk_fall |=> sync_data == $past(rx_sync_bit_i))
    else $error("receive data not set up on falling edge");

  a_tx_sample: assert property (
    s_sclk_rise_tx |=> tx_bit_valid_o && tx_bit_o == $past(txd_sync[1]))
    else $error("transmit bit not sampled on rising edge");

  a_pin_follows: assert property (
    (output_signal_select[2].sel == SEL_CRC_MATCH
      && !output_signal_select[2].inv && !sleep_i)
      |=> general_output_pin_two_o == $past(crc_match_flag))
    else $error("pin two does not follow its selected source");

  a_sleep_forced: assert property (
    (sleep_i && output_signal_select[1].sel < SEL_SLEEP_LIVE)
      |=> general_output_pin_one_o == !$past(output_signal_select[1].inv))
    else $error("pin one not forced in sleep");

  a_pin1_select: assert property (
    interface_select_low_i [*3] |-> general_output_pin_one_oe_o)
    else $error("pin one not driven while interface idle");

  a_cfg_write: assert property (
    (wr_take && hit_cfg2 && be0)
      |=> output_signal_select[2].inv == $past(avs_writedata_i[6]))
    else $error("inversion bit not written");

endmodule // sos_output_select

// ### testbench/sos_host_model.sv
// host-side model: feeds serial tx data and catches lock edges
`timescale 1ns/1ns
module sos_host_model
(
  input  wire logic clk_pin_i,
  input  wire logic status_pin_i,
  input  wire logic clr_i,
  output logic      tx_data_o,
  output logic      lock_seen_o
);
  logic [7:0] pattern = 8'hB4;

  initial tx_data_o = 1'b0;
  initial lock_seen_o = 1'b0;

  // new bit right after the falling edge, steady long before the rising one
  always @(negedge clk_pin_i)
  begin
    tx_data_o <= pattern[0];
    pattern   <= {pattern[0], pattern[7:1]};
  end

  // lock is taken from the edge, a polled level could miss a short glitch
  always @(posedge status_pin_i or posedge clr_i)
    lock_seen_o <= !clr_i;
endmodule // sos_host_model

// ### testbench/sos_output_select_bench.sv
// self-checking bench for the status output signal select block
`timescale 1ns/1ns
module sos_output_select_bench;
  import sos_pkg::*;

  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo, v;
  logic [3:0]  be = 4'hF;
  logic [8:0]  pls = 9'h000;
  logic [7:0]  preamble_quality_indicator = 8'h00, rssi = 8'h00, x;
  logic [1:0]  hard = 2'b00;
  logic        rd = 0, wr = 0, crc_eq = 0, rx_pkt = 0, pll = 0, ser_clk = 0;
  logic        ser_run = 0, sbit = 0, abit = 0, tick_s = 0, wor0 = 0, wor1 = 0;
  logic        slow = 0, sleep = 0, txa = 0, sel_n = 1, clr = 0;
  logic        wait_o, p0, oe0, p1, oe1, p2, txb, txv, host_tx, lock_seen;
  wire         w0 = oe0 ? p0 : host_tx;
  int          errors = 0, comparisons = 0, cycles = 0, n;
  logic [5:0]  codes [8] = '{SEL_PLL_LOCK, SEL_ASYNC_DATA, SEL_HARD_BIT1,
    SEL_HARD_BIT0, SEL_SYM_TICK, SEL_WOR_EVT0, SEL_WOR_EVT1, SEL_SLOW_CLK};

  sos_output_select u_sos_output_select
  (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o),
    .sync_found_i(pls[0]), .packet_end_i(pls[1]), .addr_reject_i(pls[2]),
    .rx_overflow_i(pls[3]), .tx_underflow_i(pls[4]),
    .crc_ok_packet_i(pls[5]), .rx_first_read_i(pls[6]),
    .crc_done_i(pls[7]), .crc_equal_i(crc_eq), .rx_enter_i(pls[8]),
    .preamble_quality_indicator_i(preamble_quality_indicator), .rssi_i(rssi),
    .receiving_packet_i(rx_pkt), .pll_lock_i(pll), .serial_clk_i(ser_clk),
    .rx_sync_bit_i(sbit), .rx_async_bit_i(abit),
    .receive_hard_decision_bits_i(hard), .rx_symbol_tick_i(tick_s),
    .wake_radio_event_zero_i(wor0), .wake_radio_event_one_i(wor1),
    .slow_timer_clock_i(slow), .sleep_i(sleep), .tx_active_i(txa),
    .interface_select_low_i(sel_n), .general_output_pin_zero_i(w0),
    .general_output_pin_zero_o(p0), .general_output_pin_zero_oe_o(oe0),
    .general_output_pin_one_o(p1), .general_output_pin_one_oe_o(oe1),
    .general_output_pin_two_o(p2), .tx_bit_o(txb), .tx_bit_valid_o(txv)
  );

  sos_host_model u_sos_host_model
  (
    .clk_pin_i(p1), .status_pin_i(p2), .clr_i(clr),
    .tx_data_o(host_tx), .lock_seen_o(lock_seen)
  );

  always #2 mclk_i = ~mclk_i;

  // radio serial clock, offset so its edges never meet the bench clock
  initial
  begin
    #1;
    forever #32 ser_clk = ser_run & ~ser_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] b = 4'hF);
    int k;
    k = 0;
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (wait_o !== 1'b0);
    v = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
    // one wait state, so the answer comes at the second edge
    check("bus answer", 32'(k), 2);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk_i);
    pls[k] <= 1'b1;
    @(posedge mclk_i);
    pls[k] <= 1'b0;
    tick(6);
  endtask

  task automatic drive(input logic [5:0] c, input logic b);
    @(posedge mclk_i);
    case (c)
      SEL_PLL_LOCK:   pll <= b;
      SEL_ASYNC_DATA: abit <= b;
      SEL_HARD_BIT1:  hard[1] <= b;
      SEL_HARD_BIT0:  hard[0] <= b;
      SEL_SYM_TICK:   tick_s <= b;
      SEL_WOR_EVT0:   wor0 <= b;
      SEL_WOR_EVT1:   wor1 <= b;
      default:        slow <= b;
    endcase
    tick(6);
  endtask

  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    tick(10);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      bus(0, 5'(4 * i), 32'h0);
      check("reset reg", v, 32'h0);
    end
    bus(1, ADR_THR, 32'hFFFF_FFFF, 4'h1);
    bus(0, ADR_THR, 32'h0);
    check("byte lanes", v, 32'h0000_00FF);
    bus(1, 5'h18, 32'hFFFF_FFFF);
    bus(0, 5'h18, 32'h0);
    check("unmapped", v, UNMAPPED_RD);
    bus(1, ADR_CFG0, 32'h0000_004A);
    bus(0, ADR_CFG0, 32'h0);
    check("cfg0", v, 32'h0000_004A);
    bus(0, ADR_CFG1, 32'h0);
    check("cfg1 apart", v, 32'h0);
    $display("test registers done");
    // only documented codes are programmed, never a test code
    foreach (codes[i])
      for (int inv = 0; inv < 2; inv++)
      begin
        bus(1, ADR_CFG2, {25'h0, 1'(inv), codes[i]});
        for (int b = 1; b >= 0; b--)
        begin
          drive(codes[i], 1'(b));
          check("pin2 mux", p2, 32'(b ^ inv));
        end
      end
    $display("test pass-through done");
    bus(1, ADR_CFG0, {26'h0, SEL_PKT_SYNC});
    bus(1, ADR_CFG1, {26'h0, SEL_CRC_PKT});
    bus(1, ADR_CFG2, {26'h0, SEL_CRC_MATCH});
    for (int k = 1; k < 5; k++)
    begin
      pulse(0);
      check("sync flag set", p0, 1);
      pulse(k);
      check("sync flag drop", p0, 0);
    end
    pulse(5);
    check("crc pkt set", p1, 1);
    pulse(6);
    check("crc pkt clear", p1, 0);
    for (int k = 0; k < 3; k++)
    begin
      crc_eq <= !k[0];
      pulse(7);
      check("crc match", p2, 32'(!k[0]));
    end
    pulse(8);
    check("crc match clear", p2, 0);
    $display("test flags done");
    bus(1, ADR_THR, 32'h0000_4040);
    bus(1, ADR_CFG0, {26'h0, SEL_PQ_REACHED});
    bus(1, ADR_CFG1, {26'h0, SEL_CARRIER});
    bus(1, ADR_CFG2, {26'h0, SEL_CLEAR_CHAN});
    for (int k = 0; k < 16; k++)
    begin
      bus(1, ADR_CCA, 32'(k[3:2]));
      x = 8'h3F + 8'(k[1:0]);
      preamble_quality_indicator <= x;
      rssi <= x;
      rx_pkt <= k[1];
      tick(6);
      check("pq", p0, 32'(x > 8'h40));
      check("carrier", p1, 32'(x > 8'h40));
      check("clear", p2, 32'((!k[2] || x < 8'h40) && (!k[3] || !k[1])));
    end
    $display("test thresholds done");
    clr <= 1'b1;
    bus(1, ADR_CFG0, {26'h0, SEL_WOR_EVT0});
    bus(1, ADR_CFG1, {25'h0, 1'b1, SEL_PLL_LOCK});
    bus(1, ADR_CFG2, {26'h0, SEL_PLL_LOCK});
    clr <= 1'b0;
    drive(SEL_PLL_LOCK, 1);
    check("lock edge", lock_seen, 1);
    check("pin0 apart", p0, 0);
    check("pin1 inverted", p1, 0);
    check("pin2 lock", p2, 1);
    bus(0, ADR_STATUS, 32'h0);
    check("status word", v, 32'h0000_0544);
    // pin one shows inverted async data, so forcing it low is visible
    bus(1, ADR_CFG1, {25'h0, 1'b1, SEL_ASYNC_DATA});
    sleep <= 1'b1;
    drive(SEL_WOR_EVT0, 1);
    check("sleep pin0 live", p0, 1);
    check("sleep pin1", p1, 0);
    check("sleep pin2", p2, 0);
    sleep <= 1'b0;
    sel_n <= 1'b0;
    txa <= 1'b1;
    tick(6);
    check("pin1 oe", oe1, 0);
    check("pin0 oe", oe0, 0);
    sel_n <= 1'b1;
    tick(6);
    check("pin1 oe back", oe1, 1);
    $display("test sleep and enables done");
    bus(1, ADR_CFG1, {26'h0, SEL_SER_CLK});
    bus(1, ADR_CFG2, {26'h0, SEL_SYNC_DATA});
    ser_run <= 1'b1;
    for (int b = 1; b >= 0; b--)
    begin
      @(posedge ser_clk);
      tick(1);
      sbit <= 1'(b);
      tick(5);
      check("serial clock pin", p1, 1);
      check("data held", p2, 32'(!b));
      @(negedge ser_clk);
      tick(7);
      check("data moved", p2, 32'(b));
    end
    n = 0;
    repeat (600)
    begin
      @(posedge mclk_i);
      if (txv === 1'b1)
      begin
        n++;
        check("tx bit", txb, host_tx);
      end
    end
    check("tx bit count", 32'(n > 30), 1);
    ser_run <= 1'b0;
    $display("test serial done");
    end_of_test();
  end
endmodule // sos_output_select_bench
